// ### logic/tur_tape_unit.sv
`timescale 1ns/1ns
// Functional notes
// - A tape frame is eight tracks: seven data tracks plus one sprocket track.
// - The motor power latch sets on the power button and clears once the main interlock is on.
// - The main interlock sets from the latch when both vacuum switches and the thermal switch are closed and both limit switches are open, then holds itself.
// - The reel drive enable follows the main interlock and powers reel control and capstan.
// - The vacuum drive enable is on while either the latch or the main interlock is on.
// - Select together with the rewind command starts a rewind.
// - Select together with the rewind lockout request locks the unit against further reference.
// - Select together with the forward command drives the capstan and loops forward.
// - Select together with the backward command drives the capstan and loops backward.
// - Select together with the read command connects the heads to the read amplifiers.
// - Select together with the write command connects the heads to the write flip-flops.
// - During read or write the unit reports the tape direction on exactly one of two lines.
// - A bad spot seen by the detector of the running direction suppresses reading and recording.
module tur_tape_unit (
  input  wire logic        clk,
  input  wire logic        reset,
  // Operator and tape-path switches
  input  wire logic        powerOnButton,
  input  wire logic        loopVacLeft,
  input  wire logic        loopVacRight,
  input  wire logic        thermalOk,
  input  wire logic        limitForward,
  input  wire logic        limitBackward,
  input  wire logic        badSpotForward,
  input  wire logic        badSpotBackward,
  input  wire logic        rewindComplete,
  // Controller lines
  input  wire logic        unitSelect,
  input  wire logic        rewindCommand,
  input  wire logic        rewindLockoutRequest,
  input  wire logic        forwardCommand,
  input  wire logic        backwardCommand,
  input  wire logic        readCommand,
  input  wire logic        writeCommand,
  // Head tracks
  input  wire logic [7:0]  headReadTracks,
  input  wire logic [7:0]  writeFlipFlops,
  output logic [7:0]       readAmpTracks,
  output logic [7:0]       headWriteTracks,
  output logic             headWriteEnable,
  // Relay outputs
  output logic             motorPowerLatch,
  output logic             mainInterlock,
  output logic             reelDriveEnable,
  output logic             vacuumDriveEnable,
  output logic             rewindTrigger,
  output logic             rewindLockout,
  output logic             forwardDrive,
  output logic             backwardDrive,
  output logic             readPathConnect,
  output logic             writePathConnect,
  output logic             directionForward,
  output logic             directionBackward,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [tur_pkg::PIN_REWIND_DONE_BIT:0] pinRaw;
  logic [tur_pkg::PIN_REWIND_DONE_BIT:0] pinMeta_q;
  logic [tur_pkg::PIN_REWIND_DONE_BIT:0] pinSync_q;
  logic [7:0]                            trackMeta_q;
  logic [7:0]                            trackSync_q;
  logic [7:0]                            wffMeta_q;
  logic [7:0]                            wffSync_q;

  assign pinRaw = {rewindComplete, badSpotBackward, badSpotForward,
                   writeCommand, readCommand, backwardCommand,
                   forwardCommand, rewindLockoutRequest, rewindCommand,
                   unitSelect, limitBackward, limitForward, thermalOk,
                   loopVacRight, loopVacLeft, powerOnButton};

  // Every switch and controller line is asynchronous to clk
  always_ff @(posedge clk) begin
    if (reset) begin
      pinMeta_q   <= '0;
      pinSync_q   <= '0;
      trackMeta_q <= '0;
      trackSync_q <= '0;
      wffMeta_q   <= '0;
      wffSync_q   <= '0;
    end else begin
      pinMeta_q   <= pinRaw;
      pinSync_q   <= pinMeta_q;
      trackMeta_q <= headReadTracks;
      trackSync_q <= trackMeta_q;
      wffMeta_q   <= writeFlipFlops;
      wffSync_q   <= wffMeta_q;
    end
  end

  wire buttonS   = pinSync_q[tur_pkg::PIN_POWER_BUTTON];
  wire vacLeftS  = pinSync_q[tur_pkg::PIN_VAC_LEFT];
  wire vacRightS = pinSync_q[tur_pkg::PIN_VAC_RIGHT];
  wire thermalS  = pinSync_q[tur_pkg::PIN_THERMAL];
  wire limFwdS   = pinSync_q[tur_pkg::PIN_LIMIT_FWD];
  wire limBwdS   = pinSync_q[tur_pkg::PIN_LIMIT_BWD];
  wire selectS   = pinSync_q[tur_pkg::PIN_SELECT];
  wire rewindS   = pinSync_q[tur_pkg::PIN_REWIND];
  wire lockReqS  = pinSync_q[tur_pkg::PIN_LOCKOUT_REQ];
  wire fwdCmdS   = pinSync_q[tur_pkg::PIN_FORWARD];
  wire bwdCmdS   = pinSync_q[tur_pkg::PIN_BACKWARD];
  wire readCmdS  = pinSync_q[tur_pkg::PIN_READ];
  wire writeCmdS = pinSync_q[tur_pkg::PIN_WRITE];
  wire badFwdS   = pinSync_q[tur_pkg::PIN_BAD_FWD];
  wire badBwdS   = pinSync_q[tur_pkg::PIN_BAD_BWD];
  wire rewDoneS  = pinSync_q[tur_pkg::PIN_REWIND_DONE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [1:0]  ctrl_q;
  logic [7:0]  addrPhase_q;
  logic        writePhase_q;
  logic [31:0] rdata_q;
  logic        lockClear;
  logic [tur_pkg::STATUS_WIDTH-1:0] status;

  wire busTake  = hsel & hready & htrans[1];
  wire ctrlHit  = addrPhase_q == tur_pkg::CTRL_OFFSET;
  wire ctrlWr   = writePhase_q & ctrlHit;
  wire unitOn   = ctrl_q[tur_pkg::CTRL_ENABLE_BIT];
  wire powerOff = ctrl_q[tur_pkg::CTRL_POWER_OFF_BIT];
  assign lockClear = ctrlWr & hwdata[tur_pkg::CTRL_LOCK_CLEAR_BIT];

  wire [31:0] readMux =
      (haddr[7:0] == tur_pkg::CTRL_OFFSET)   ? {30'h0, ctrl_q} :
      (haddr[7:0] == tur_pkg::STATUS_OFFSET) ?
          {{(32 - tur_pkg::STATUS_WIDTH){1'b0}}, status} :
      (haddr[7:0] == tur_pkg::PINS_OFFSET)   ? {16'h0, pinSync_q} :
      32'h0;

  // Read data is captured in the address phase so hrdata is a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      addrPhase_q  <= 8'h00;
      writePhase_q <= 1'b0;
      rdata_q      <= 32'h0;
    end else begin
      writePhase_q <= busTake & hwrite;
      if (busTake) begin
        addrPhase_q <= haddr[7:0];
        rdata_q     <= hwrite ? 32'h0 : readMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= tur_pkg::CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Power interlock chain

  logic latch_q;
  logic interlock_q;
  logic reel_q;
  logic vacuum_q;

  // The hold path runs through the same switches, so a loop loss,
  // overheat or end of tape drops the interlock
  wire pathOk = vacLeftS & vacRightS & thermalS & ~limFwdS & ~limBwdS;
  wire interlockD = pathOk & ~powerOff & (latch_q | interlock_q);
  wire latchD = (latch_q | buttonS) & ~interlock_q & ~powerOff;

  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q     <= 1'b0;
      interlock_q <= 1'b0;
      reel_q      <= 1'b0;
      vacuum_q    <= 1'b0;
    end else begin
      latch_q     <= latchD;
      interlock_q <= interlockD;
      reel_q      <= interlockD;
      vacuum_q    <= latchD | interlockD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic rewind_q;
  logic lockout_q;
  logic fwd_q;
  logic bwd_q;
  logic read_q;
  logic write_q;
  logic dirFwd_q;
  logic dirRep_q;
  logic bad_q;

  // A locked unit ignores its select until software releases it
  wire selected = selectS & unitOn & ~lockout_q;
  wire running  = interlock_q;
  wire rewindD  = (rewind_q & ~rewDoneS) |
                  (selected & rewindS & running);
  wire lockoutD = (selected & lockReqS) |
                  (lockout_q & ~lockClear);
  // Forward wins if both arrive; the controller must not send both
  wire fwdD   = selected & fwdCmdS & running & ~rewindD;
  wire bwdD   = selected & bwdCmdS & ~fwdCmdS & running
                & ~rewindD;
  wire readD  = selected & readCmdS;
  wire writeD = selected & writeCmdS & ~readCmdS;
  wire badD   = (fwdD & badFwdS) | (bwdD & badBwdS);
  wire dirD   = fwdD | (dirFwd_q & ~bwdD);

  always_ff @(posedge clk) begin
    if (reset) begin
      rewind_q  <= 1'b0;
      lockout_q <= 1'b0;
      fwd_q     <= 1'b0;
      bwd_q     <= 1'b0;
      read_q    <= 1'b0;
      write_q   <= 1'b0;
      dirFwd_q  <= 1'b1;
      dirRep_q  <= 1'b0;
      bad_q     <= 1'b0;
    end else begin
      rewind_q  <= rewindD;
      lockout_q <= lockoutD;
      fwd_q     <= fwdD;
      bwd_q     <= bwdD;
      read_q    <= readD;
      write_q   <= writeD;
      dirFwd_q  <= dirD;
      dirRep_q  <= readD | writeD;
      bad_q     <= badD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Head track switching

  logic [7:0] readOut_q;
  logic [7:0] writeOut_q;
  logic       writeEn_q;

  wire readGate  = readD & ~badD;
  wire writeGate = writeD & ~badD;

  // Sprocket sits on its own track beside the seven data tracks
  wire [7:0] frameIn  = {trackSync_q[tur_pkg::SPROCKET_BIT],
                         trackSync_q[tur_pkg::DATA_TRACKS-1:0]};
  wire [7:0] frameOut = {wffSync_q[tur_pkg::SPROCKET_BIT],
                         wffSync_q[tur_pkg::DATA_TRACKS-1:0]};

  always_ff @(posedge clk) begin
    if (reset) begin
      readOut_q  <= 8'h00;
      writeOut_q <= 8'h00;
      writeEn_q  <= 1'b0;
    end else begin
      readOut_q  <= readGate ? frameIn : 8'h00;
      writeOut_q <= writeGate ? frameOut : 8'h00;
      writeEn_q  <= writeGate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and status

  assign status = {bad_q, dirRep_q & ~dirFwd_q, dirRep_q & dirFwd_q,
                   write_q, read_q, bwd_q, fwd_q, lockout_q, rewind_q,
                   vacuum_q, reel_q, interlock_q, latch_q};

  logic dirOutF_q;
  logic dirOutB_q;

  // One line only, chosen by last direction of motion
  always_ff @(posedge clk) begin
    if (reset) begin
      dirOutF_q <= 1'b0;
      dirOutB_q <= 1'b0;
    end else begin
      dirOutF_q <= (readD | writeD) & dirD;
      dirOutB_q <= (readD | writeD) & ~dirD;
    end
  end

  assign readAmpTracks     = readOut_q;
  assign headWriteTracks   = writeOut_q;
  assign headWriteEnable   = writeEn_q;
  assign motorPowerLatch   = latch_q;
  assign mainInterlock     = interlock_q;
  assign reelDriveEnable   = reel_q;
  assign vacuumDriveEnable = vacuum_q;
  assign rewindTrigger     = rewind_q;
  assign rewindLockout     = lockout_q;
  assign forwardDrive      = fwd_q;
  assign backwardDrive     = bwd_q;
  assign readPathConnect   = read_q;
  assign writePathConnect  = write_q;
  assign directionForward  = dirOutF_q;
  assign directionBackward = dirOutB_q;

endmodule : tur_tape_unit

// ### logic/tur_pkg.sv
package tur_pkg;

  localparam int TRACK_COUNT = 8;
  localparam int DATA_TRACKS = 7;
  localparam int SPROCKET_BIT = 7;

  // Positions of the pin inputs inside the synchronised pin vector
  localparam int PIN_COUNT = 16;
  localparam int PIN_POWER_BUTTON = 0;
  localparam int PIN_VAC_LEFT = 1;
  localparam int PIN_VAC_RIGHT = 2;
  localparam int PIN_THERMAL = 3;
  localparam int PIN_LIMIT_FWD = 4;
  localparam int PIN_LIMIT_BWD = 5;
  localparam int PIN_SELECT = 6;
  localparam int PIN_REWIND = 7;
  localparam int PIN_LOCKOUT_REQ = 8;
  localparam int PIN_FORWARD = 9;
  localparam int PIN_BACKWARD = 10;
  localparam int PIN_READ = 11;
  localparam int PIN_WRITE = 12;
  localparam int PIN_BAD_FWD = 13;
  localparam int PIN_BAD_BWD = 14;
  localparam int PIN_REWIND_DONE_BIT = 15;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] PINS_OFFSET = 8'h08;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_POWER_OFF_BIT = 1;
  localparam int CTRL_LOCK_CLEAR_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Status register fields
  localparam int ST_LATCH = 0;
  localparam int ST_INTERLOCK = 1;
  localparam int ST_REEL = 2;
  localparam int ST_VACUUM = 3;
  localparam int ST_REWIND = 4;
  localparam int ST_LOCKOUT = 5;
  localparam int ST_FORWARD = 6;
  localparam int ST_BACKWARD = 7;
  localparam int ST_READ = 8;
  localparam int ST_WRITE = 9;
  localparam int ST_DIR_FWD = 10;
  localparam int ST_DIR_BWD = 11;
  localparam int ST_BAD_SPOT = 12;
  localparam int STATUS_WIDTH = 13;

endpackage : tur_pkg

// ### tb/tur_io_control.sv
`timescale 1ns/1ns
module tur_io_control #(
  parameter logic [3:0] UNIT = 4'h5
) (
  input  wire logic       clk,
  input  wire logic       reqValid,
  input  wire logic [3:0] reqUnit,
  input  wire logic [1:0] reqDir,
  input  wire logic [1:0] reqXfer,
  input  wire logic       reqRewind,
  input  wire logic       reqLock,
  output logic            unitSelect,
  output logic            rewindCommand,
  output logic            rewindLockoutRequest,
  output logic            forwardCommand,
  output logic            backwardCommand,
  output logic            readCommand,
  output logic            writeCommand
);
  // Encoded requests cannot ask for read with write or both directions
  always_ff @(posedge clk) begin
    unitSelect           <= reqValid && reqUnit == UNIT;
    forwardCommand       <= reqDir == 2'h1;
    backwardCommand      <= reqDir == 2'h2;
    readCommand          <= reqXfer == 2'h1;
    writeCommand         <= reqXfer == 2'h2;
    rewindCommand        <= reqRewind;
    rewindLockoutRequest <= reqLock;
  end
endmodule : tur_io_control

// ### tb/tur_tape_unit_monitor.sv
`timescale 1ns/1ns
module tur_tape_unit_monitor (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       loopVacLeft,
  input wire logic       loopVacRight,
  input wire logic       thermalOk,
  input wire logic       limitForward,
  input wire logic       limitBackward,
  input wire logic       badSpotForward,
  input wire logic       unitSelect,
  input wire logic       rewindCommand,
  input wire logic       rewindLockoutRequest,
  input wire logic       forwardCommand,
  input wire logic       readCommand,
  input wire logic [7:0] readAmpTracks,
  input wire logic       motorPowerLatch,
  input wire logic       mainInterlock,
  input wire logic       reelDriveEnable,
  input wire logic       vacuumDriveEnable,
  input wire logic       rewindTrigger,
  input wire logic       rewindLockout,
  input wire logic       forwardDrive,
  input wire logic       backwardDrive,
  input wire logic       readPathConnect,
  input wire logic       writePathConnect,
  input wire logic       directionForward,
  input wire logic       directionBackward
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_ilk_up;
    !mainInterlock ##1 mainInterlock;
  endsequence
  // Pins pass two sync stages and one output flop
  property p_latch; s_ilk_up |=> !motorPowerLatch; endproperty
  a_latch: assert property (p_latch)
    else $error("latch stays on");
  property p_ilk;
    $rose(mainInterlock) |-> $past(motorPowerLatch)
      && $past(loopVacLeft, 3) && $past(loopVacRight, 3)
      && $past(thermalOk, 3) && !$past(limitForward, 3)
      && !$past(limitBackward, 3);
  endproperty
  a_ilk: assert property (p_ilk)
    else $error("interlock without cause");
  property p_reel; reelDriveEnable == mainInterlock; endproperty
  a_reel: assert property (p_reel)
    else $error("reel drive mismatch");
  property p_vac;
    vacuumDriveEnable == (motorPowerLatch || mainInterlock);
  endproperty
  a_vac: assert property (p_vac)
    else $error("vacuum drive mismatch");
  property p_rew;
    $rose(rewindTrigger) |-> $past(unitSelect, 3)
      && $past(rewindCommand, 3);
  endproperty
  a_rew: assert property (p_rew)
    else $error("rewind without command");
  property p_lock;
    $rose(rewindLockout) |-> $past(unitSelect, 3)
      && $past(rewindLockoutRequest, 3);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lockout without cause");
  property p_fwd;
    forwardDrive |-> $past(unitSelect, 3) && $past(forwardCommand, 3)
      && !backwardDrive;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward drive wrong");
  property p_rd;
    readPathConnect |-> $past(unitSelect, 3) && $past(readCommand, 3)
      && !writePathConnect;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read path wrong");
  property p_dir;
    readPathConnect || writePathConnect |->
      directionForward != directionBackward;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction report wrong");
  property p_bad;
    readPathConnect && directionForward && $past(badSpotForward, 3)
      |-> readAmpTracks == 8'h00;
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad spot not muted");
endmodule : tur_tape_unit_monitor

bind tur_tape_unit tur_tape_unit_monitor tur_tape_unit_monitor_inst (
  .clk, .reset, .loopVacLeft, .loopVacRight, .thermalOk, .limitForward,
  .limitBackward, .badSpotForward, .unitSelect, .rewindCommand,
  .rewindLockoutRequest, .forwardCommand, .readCommand, .readAmpTracks,
  .motorPowerLatch, .mainInterlock, .reelDriveEnable, .vacuumDriveEnable,
  .rewindTrigger, .rewindLockout, .forwardDrive, .backwardDrive,
  .readPathConnect, .writePathConnect, .directionForward, .directionBackward);

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  typedef struct {
    string       what;
    logic [31:0] e;
    logic [31:0] m;
    bit          bus;
  } tur_note_type;
  logic        clk = 1'b0, reset = 1'b1, powerOnButton = 1'b0;
  logic        loopVacLeft = 1'b0, loopVacRight = 1'b0, thermalOk = 1'b0;
  logic        limitForward = 1'b0, limitBackward = 1'b0, reqLock = 1'b0;
  logic        badSpotForward = 1'b0, badSpotBackward = 1'b0;
  logic        rewindComplete = 1'b0, reqValid = 1'b0, reqRewind = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [3:0]  reqUnit = 4'h0;
  logic [1:0]  reqDir = 2'h0, reqXfer = 2'h0, htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [7:0]  headReadTracks = 8'h00, writeFlipFlops = 8'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdVal;
  wire         unitSelect, rewindCommand, rewindLockoutRequest;
  wire         forwardCommand, backwardCommand, readCommand, writeCommand;
  wire         motorPowerLatch, mainInterlock, reelDriveEnable;
  wire         vacuumDriveEnable, rewindTrigger, rewindLockout, forwardDrive;
  wire         backwardDrive, readPathConnect, writePathConnect;
  wire         directionForward, directionBackward, headWriteEnable;
  wire         hreadyout, hresp;
  wire  [7:0]  readAmpTracks, headWriteTracks;
  wire  [31:0] hrdata;
  wire         hready = hreadyout;
  wire  [31:0] outs = {2'h0, hresp, headWriteEnable, headWriteTracks,
    readAmpTracks, motorPowerLatch, mainInterlock, reelDriveEnable,
    vacuumDriveEnable,
    rewindTrigger, rewindLockout, forwardDrive, backwardDrive,
    readPathConnect, writePathConnect, directionForward, directionBackward};
  tur_note_type q[$];
  event        chk;
  int          fails = 0;
  int          num_checks = 0;
  logic [1:0]  dirT [4] = '{2'h1, 2'h2, 2'h1, 2'h2};
  logic [1:0]  xfrT [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
  logic [11:0] relT [4] = '{12'h72a, 12'h715, 12'h726, 12'h719};

  tur_io_control #(.UNIT(4'h5)) tur_io_control_inst (.clk, .reqValid,
    .reqUnit, .reqDir, .reqXfer, .reqRewind, .reqLock, .unitSelect,
    .rewindCommand, .rewindLockoutRequest, .forwardCommand, .backwardCommand,
    .readCommand, .writeCommand);
  tur_tape_unit tur_tape_unit_inst (.clk, .reset, .powerOnButton,
    .loopVacLeft, .loopVacRight, .thermalOk, .limitForward, .limitBackward,
    .badSpotForward, .badSpotBackward, .rewindComplete, .unitSelect,
    .rewindCommand, .rewindLockoutRequest, .forwardCommand, .backwardCommand,
    .readCommand, .writeCommand, .headReadTracks, .writeFlipFlops,
    .readAmpTracks, .headWriteTracks, .headWriteEnable, .motorPowerLatch,
    .mainInterlock, .reelDriveEnable, .vacuumDriveEnable, .rewindTrigger,
    .rewindLockout, .forwardDrive, .backwardDrive, .readPathConnect,
    .writePathConnect, .directionForward, .directionBackward, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task note(input string w, input logic [31:0] e, m, input bit b);
    q.push_back('{w, e, m, b});
    ->chk;
    #1;
  endtask : note
  // Waits on hready although this slave never stalls
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdVal = hrdata;
  endtask : bus
  task req(input logic [3:0] u, input logic [1:0] d, x, input logic r, l);
    @(posedge clk);
    reqValid <= 1'b1; reqUnit <= u; reqDir <= d; reqXfer <= x;
    reqRewind <= r; reqLock <= l;
  endtask : req
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  always @(chk) begin : mon
    tur_note_type n;
    logic [31:0]  a;
    n = q.pop_front();
    a = n.bus ? rdVal : outs;
    num_checks++;
    if ((a & n.m) !== n.e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n.what, n.e, a & n.m);
    end
  end
  initial begin
    #30000;
    fails++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h58447fb8));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    settle(2);
    note("outputs", 32'h0, 32'hffffffff, 0);
    bus(0, tur_pkg::CTRL_OFFSET, 0); note("ctrl", 32'h1, '1, 1);
    bus(0, 8'h0c, 0); note("unmapped", 32'h0, '1, 1);
    $display("test reset done");
    @(posedge clk) {powerOnButton, loopVacRight, thermalOk} <= 3'h7;
    settle(2);
    @(posedge clk) powerOnButton <= 1'b0;
    settle(4);
    note("latch", 32'h900, 32'hfff, 0);
    @(posedge clk) loopVacLeft <= 1'b1;
    settle(5);
    note("interlock", 32'h700, 32'hfff, 0);
    bus(0, tur_pkg::STATUS_OFFSET, 0);
    note("status", 32'he, '1, 1);
    $display("test power done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      headReadTracks <= 8'($urandom); writeFlipFlops <= 8'($urandom);
      req(4'h5, dirT[i], xfrT[i], 0, 0);
      settle(5);
      note("xfer", {3'h0, xfrT[i] == 2'h2,
        xfrT[i] == 2'h2 ? writeFlipFlops : 8'h00,
        xfrT[i] == 2'h1 ? headReadTracks : 8'h00,
        relT[i]}, '1, 0);
      req(4'h5, 0, 0, 0, 0); settle(5);
      note("idle", 32'h700, 32'hfffffffc, 0);
    end
    req(4'h6, 1, 1, 0, 0); settle(5);
    note("other unit", 32'h700, 32'hfffffffc, 0);
    req(4'h5, 1, 1, 0, 0);
    @(posedge clk) badSpotForward <= 1'b1;
    settle(5);
    note("bad spot", 32'h72a, '1, 0);
    @(posedge clk) badSpotForward <= 1'b0;
    req(4'h5, 0, 0, 0, 0); settle(5);
    // Backward write over a marked area: recording must stay off
    @(posedge clk) badSpotBackward <= 1'b1;
    req(4'h5, 2, 2, 0, 0);
    settle(5);
    note("bad spot back", 32'h715, '1, 0);
    @(posedge clk) badSpotBackward <= 1'b0;
    req(4'h5, 0, 0, 0, 0);
    settle(5);
    $display("test transfer done");
    req(4'h5, 0, 0, 1, 0); settle(5);
    req(4'h5, 0, 0, 0, 0); settle(5);
    note("rewind", 32'h780, 32'hfffffffc, 0);
    @(posedge clk) rewindComplete <= 1'b1;
    settle(5);
    note("rewind end", 32'h700, 32'hfffffffc, 0);
    @(posedge clk) rewindComplete <= 1'b0;
    req(4'h5, 0, 0, 0, 1); settle(5);
    req(4'h5, 1, 1, 0, 0); settle(5);
    note("lockout", 32'h740, 32'hfffffffc, 0);
    req(4'h5, 0, 0, 0, 0);
    bus(1, tur_pkg::CTRL_OFFSET, 32'h5); settle(2);
    note("lock clear", 32'h700, 32'hfffffffc, 0);
    $display("test lockout done");
    // Selected, switches good, no commands: select, vacL, vacR, thermal
    bus(0, tur_pkg::PINS_OFFSET, 0);
    note("pins", 32'h4e, '1, 1);
    // A disabled unit ignores its select
    bus(1, tur_pkg::CTRL_OFFSET, 32'h0);
    req(4'h5, 1, 1, 0, 0);
    settle(5);
    note("disabled", 32'h700, '1, 0);
    // Software power off drops the whole interlock chain
    bus(1, tur_pkg::CTRL_OFFSET, 32'h2);
    settle(2);
    note("power off", 32'h0, '1, 0);
    $display("test control done");
    wrap_up();
  end
endmodule : tb_top
